// File: msfs_defs.svh
// register offsets, field positions, reset values and timing counts
// for the motor starter fault supervisor; included by its bare name
`ifndef MSFS_DEFS_SVH
`define MSFS_DEFS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define MSFS_CTRL_OFS      8'h00
`define MSFS_CMD_OFS       8'h04
`define MSFS_STATUS_OFS    8'h08
`define MSFS_HIST0_OFS     8'h0C
`define MSFS_HIST_LAST_OFS 8'h1C

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define MSFS_CTRL_THREE_WIRE 0
`define MSFS_CTRL_ISOLATING  1
`define MSFS_CTRL_PH_CHECK   2
`define MSFS_CTRL_PH_ORDER   3
`define MSFS_CTRL_FREQ_CHECK 4
`define MSFS_CTRL_THREE_PH   5
`define MSFS_CTRL_AUTORESET  6
`define MSFS_CTRL_INPUT_RST  7
`define MSFS_CTRL_THR_LSB    8
`define MSFS_CTRL_THR_MSB    15
`define MSFS_CTRL_RESET      16'h4064

// ----------------------------------------------------------------
// command and status fields
// ----------------------------------------------------------------
`define MSFS_CMD_CLR_CFG_PU  0
`define MSFS_CMD_CLR_CFG_SER 1
`define MSFS_ST_STATE_LSB    0
`define MSFS_ST_CODE_LSB     4
`define MSFS_ST_RETRY_LSB    8
`define MSFS_ST_RELAY1       12
`define MSFS_ST_RELAY2       13
`define MSFS_ST_DRIVE        14
`define MSFS_ST_CFG_PU       15
`define MSFS_ST_CFG_SER      16

// ----------------------------------------------------------------
// timing and counts
// ----------------------------------------------------------------
`define MSFS_CLK_HZ      64'd200000000
`define MSFS_RETRY_S     64'd60
`define MSFS_PL_1PH_MS   64'd500
`define MSFS_PL_3PH_MS   64'd200
`define MSFS_CS_LOSS_MS  64'd200
`define MSFS_FLASH_MS    64'd250
`define MSFS_RETRY_CYC   (`MSFS_RETRY_S * `MSFS_CLK_HZ)
`define MSFS_PL_1PH_CYC  (`MSFS_PL_1PH_MS * `MSFS_CLK_HZ / 64'd1000)
`define MSFS_PL_3PH_CYC  (`MSFS_PL_3PH_MS * `MSFS_CLK_HZ / 64'd1000)
`define MSFS_CS_LOSS_CYC (`MSFS_CS_LOSS_MS * `MSFS_CLK_HZ / 64'd1000)
`define MSFS_FLASH_CYC   (`MSFS_FLASH_MS * `MSFS_CLK_HZ / 64'd1000)
`define MSFS_RETRY_MAX   3'd6
`define MSFS_HIST_DEPTH  5

`endif

// File: msfs_pkg.sv
// types shared by the motor starter fault supervisor
// assumes msfs_defs.svh for widths of history depth
`include "msfs_defs.svh"

package msfs_pkg;

  typedef enum logic [2:0] {
    MSFS_OK, MSFS_LOCK_NR, MSFS_LOCK_RS, MSFS_LOCK_AR, MSFS_LOCK_MAN
  } msfs_state_t;

  typedef enum logic [3:0] {
    MSFS_FC_NONE, MSFS_FC_INTERNAL, MSFS_FC_OVERCURRENT,
    MSFS_FC_PHASE_INV, MSFS_FC_MEMORY, MSFS_FC_CFG_POWERUP,
    MSFS_FC_SERIAL_CFG, MSFS_FC_PHASE_LOSS, MSFS_FC_LINE_FREQ,
    MSFS_FC_CTL_LINE
  } msfs_code_t;

  // line, motor and internal monitoring inputs
  typedef struct packed {
    logic [7:0] motor_current;
    logic       line_phase_order;
    logic       line_phase_lost;
    logic       line_freq_out;
    logic       internal_fault;
    logic       overcurrent;
    logic       memory_fault;
    logic       cfg_invalid;
    logic       serial_cfg_bad;
    logic       ctl_supply_present;
  } msfs_mon_t;

  // run command terminals and logic input
  typedef struct packed {
    logic run;
    logic stop;
    logic fault_reset;
  } msfs_cmd_t;

  // outputs toward relays, power stage and display
  typedef struct packed {
    logic       fault_isolation_relay;
    logic       second_relay_output;
    logic       motor_drive;
    msfs_code_t fault_code;
    logic       display_on;
  } msfs_out_t;

  typedef struct packed {
    msfs_state_t                         st;
    msfs_code_t                          code;
    msfs_out_t                           out;
    logic                                flash;
    logic [26:0]                         flash_cnt;
    logic [26:0]                         pl_cnt;
    logic                                pl_fault;
    logic [26:0]                         cs_cnt;
    logic                                cs_lost;
    logic [35:0]                         retry_cnt;
    logic [2:0]                          retries;
    logic                                run_q;
    logic                                start_latch;
    logic                                cfg_pu;
    logic                                cfg_ser;
    logic                                pu_done;
    logic [15:0]                         ctrl;
    logic [`MSFS_HIST_DEPTH-1:0][3:0]    hist;
    logic [31:0]                         prdata;
    logic                                pready;
    logic                                pslverr;
  } msfs_regs_t;

endpackage : msfs_pkg

// File: msfs_supervisor.sv
// fault supervisor of a motor soft starter with an apb register slave
// assumes monitoring and run inputs synchronous to pclk
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`include "msfs_defs.svh"

// Notes on behaviour
// - non-resettable fault locks, motor coasts
// - second relay opens; isolation relay after lockout
// - non-resettable cleared only by supply cycling
// - phase order mismatch gives inversion fault
// - present resettable/auto fault code flashes
// - five newest fault events kept, oldest dropped
// - resettable fault locks, coasts, opens second relay
// - first relay opens only when isolating
// - 2-wire resumes with run held after clear
// - 3-wire restarts only on fresh run edge
// - invalid stored config at power-up faults
// - incompatible serial config gives own fault
// - auto-reset fault restarts itself once cleared
// - fault relay stays closed during auto-reset unless isolating
// - six retries spaced sixty seconds apart
// - still present at sixth retry trips manual
// - low current 0.5 s/0.2 s is phase loss
// - lost line phase gives same phase code
// - configurable line frequency tolerance fault
// - control supply absent over 200 ms faults
// - manual fault cleared by new run edge, or by fault_reset instead when input_rst set
module msfs_supervisor #(
  parameter logic [35:0] RETRY_CYC   = 36'(`MSFS_RETRY_CYC),
  parameter logic [26:0] PL_1PH_CYC  = 27'(`MSFS_PL_1PH_CYC),
  parameter logic [26:0] PL_3PH_CYC  = 27'(`MSFS_PL_3PH_CYC),
  parameter logic [26:0] CS_LOSS_CYC = 27'(`MSFS_CS_LOSS_CYC),
  parameter logic [26:0] FLASH_CYC   = 27'(`MSFS_FLASH_CYC)
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire msfs_pkg::msfs_mon_t mon,
  input  wire msfs_pkg::msfs_cmd_t cmd,
  output msfs_pkg::msfs_out_t    outs
);
  import msfs_pkg::*;

  // ----------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------
  function automatic logic [1:0] rank(input msfs_state_t s);
    unique case (s)
      MSFS_OK:       rank = 2'd0;
      MSFS_LOCK_AR:  rank = 2'd1;
      MSFS_LOCK_MAN: rank = 2'd1;
      MSFS_LOCK_RS:  rank = 2'd2;
      MSFS_LOCK_NR:  rank = 2'd3;
    endcase
  endfunction : rank

  function automatic logic addr_hit(input logic [7:0] a,
                                    input logic [7:0] ofs);
    addr_hit = (a == ofs);
  endfunction : addr_hit

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  msfs_regs_t  r_reg;
  msfs_regs_t  r_next;

  logic        three_wire;
  logic        iso;
  logic        autoreset;
  logic        input_rst;
  logic        run_rise;
  logic        nr_cond;
  logic        rs_cond;
  logic        ar_cond;
  msfs_code_t  top;
  logic        low_cur;
  logic [26:0] pl_lim;
  logic        apb_wr;
  logic        apb_rd;
  logic        hist_sel;
  logic [2:0]  hist_idx;
  logic [7:0]  hist_ofs;
  logic        retry_due;

  assign three_wire = r_reg.ctrl[`MSFS_CTRL_THREE_WIRE];
  assign iso        = r_reg.ctrl[`MSFS_CTRL_ISOLATING];
  assign autoreset  = r_reg.ctrl[`MSFS_CTRL_AUTORESET];
  assign input_rst  = r_reg.ctrl[`MSFS_CTRL_INPUT_RST];
  assign run_rise   = cmd.run & ~r_reg.run_q;
  assign low_cur    = mon.motor_current <
                      r_reg.ctrl[`MSFS_CTRL_THR_MSB:`MSFS_CTRL_THR_LSB];
  assign pl_lim     = r_reg.ctrl[`MSFS_CTRL_THREE_PH] ? PL_3PH_CYC
                                                      : PL_1PH_CYC;
  // a write lands only at the access edge that samples pready high
  assign apb_wr     = psel & penable & pwrite & r_reg.pready;
  assign apb_rd     = psel & ~penable & ~pwrite;
  assign hist_ofs   = paddr - `MSFS_HIST0_OFS;
  assign hist_sel   = (paddr >= `MSFS_HIST0_OFS) &&
                      (paddr <= `MSFS_HIST_LAST_OFS) &&
                      (paddr[1:0] == 2'b00);
  assign hist_idx   = hist_ofs[4:2];
  assign retry_due  = (r_reg.retry_cnt >= RETRY_CYC - 36'd1);

  // ----------------------------------------------------------------
  // fault sorting by class, most severe first
  // ----------------------------------------------------------------
  always_comb begin
    top = MSFS_FC_NONE;
    if (r_reg.ctrl[`MSFS_CTRL_FREQ_CHECK] & mon.line_freq_out) begin
      top = MSFS_FC_LINE_FREQ;
    end
    if (r_reg.pl_fault | mon.line_phase_lost) begin
      top = MSFS_FC_PHASE_LOSS;
    end
    if (r_reg.cs_cnt >= CS_LOSS_CYC) begin
      top = MSFS_FC_CTL_LINE;
    end
    if (r_reg.cfg_ser) begin
      top = MSFS_FC_SERIAL_CFG;
    end
    if (r_reg.cfg_pu) begin
      top = MSFS_FC_CFG_POWERUP;
    end
    if (mon.memory_fault) begin
      top = MSFS_FC_MEMORY;
    end
    if (r_reg.ctrl[`MSFS_CTRL_PH_CHECK] &
        (mon.line_phase_order != r_reg.ctrl[`MSFS_CTRL_PH_ORDER])) begin
      top = MSFS_FC_PHASE_INV;
    end
    if (mon.overcurrent) begin
      top = MSFS_FC_OVERCURRENT;
    end
    if (mon.internal_fault) begin
      top = MSFS_FC_INTERNAL;
    end
    nr_cond = (top == MSFS_FC_INTERNAL) || (top == MSFS_FC_OVERCURRENT) ||
              (top == MSFS_FC_PHASE_INV) || (top == MSFS_FC_MEMORY);
    rs_cond = (top == MSFS_FC_CFG_POWERUP) || (top == MSFS_FC_SERIAL_CFG);
    ar_cond = (top == MSFS_FC_CTL_LINE) || (top == MSFS_FC_PHASE_LOSS) ||
              (top == MSFS_FC_LINE_FREQ);
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    r_next.run_q = cmd.run;

    // power-up configuration check, caught once after reset release
    if (!r_reg.pu_done) begin
      r_next.pu_done = 1'b1;
      r_next.cfg_pu  = mon.cfg_invalid;
    end
    if (apb_wr && addr_hit(paddr, `MSFS_CMD_OFS) &&
        pwdata[`MSFS_CMD_CLR_CFG_PU] && r_reg.pu_done) begin
      r_next.cfg_pu = 1'b0;
    end
    // set wins over a clear in the same cycle
    if (apb_wr && addr_hit(paddr, `MSFS_CMD_OFS) &&
        pwdata[`MSFS_CMD_CLR_CFG_SER]) begin
      r_next.cfg_ser = 1'b0;
    end
    if (mon.serial_cfg_bad) begin
      r_next.cfg_ser = 1'b1;
    end
    if (apb_wr && addr_hit(paddr, `MSFS_CTRL_OFS)) begin
      r_next.ctrl = pwdata[15:0];
    end

    // control supply absence timer
    if (mon.ctl_supply_present) begin
      r_next.cs_cnt = 27'd0;
    end else if (r_reg.cs_cnt < CS_LOSS_CYC) begin
      r_next.cs_cnt = r_reg.cs_cnt + 27'd1;
    end

    // motor phase loss while driving
    if (r_reg.out.motor_drive && low_cur) begin
      if (r_reg.pl_cnt >= pl_lim - 27'd1) begin
        r_next.pl_fault = 1'b1;
      end else begin
        r_next.pl_cnt = r_reg.pl_cnt + 27'd1;
      end
    end else begin
      r_next.pl_cnt = 27'd0;
    end

    // fault state machine
    unique case (r_reg.st)
      MSFS_OK: begin
        r_next.retries = 3'd0;
        if (nr_cond) begin
          r_next.st = MSFS_LOCK_NR;
        end else if (rs_cond) begin
          r_next.st = MSFS_LOCK_RS;
        end else if (ar_cond) begin
          r_next.st = autoreset ? MSFS_LOCK_AR : MSFS_LOCK_MAN;
        end
      end
      MSFS_LOCK_NR: begin
        if (!mon.ctl_supply_present) begin
          r_next.cs_lost = 1'b1;
        end else if (r_reg.cs_lost) begin
          r_next.cs_lost = 1'b0;
          r_next.st      = MSFS_OK;
        end
      end
      MSFS_LOCK_RS: begin
        if (nr_cond) begin
          r_next.st = MSFS_LOCK_NR;
        end else if (!rs_cond) begin
          r_next.st = MSFS_OK;
        end
      end
      MSFS_LOCK_AR: begin
        r_next.retry_cnt = r_reg.retry_cnt + 36'd1;
        if (nr_cond) begin
          r_next.st = MSFS_LOCK_NR;
        end else if (rs_cond) begin
          r_next.st = MSFS_LOCK_RS;
        end else if (!ar_cond) begin
          r_next.st      = MSFS_OK;
          r_next.retries = 3'd0;
        end else if (retry_due) begin
          r_next.retry_cnt = 36'd0;
          r_next.pl_fault  = 1'b0;
          r_next.retries   = r_reg.retries + 3'd1;
          if (r_reg.retries + 3'd1 >= `MSFS_RETRY_MAX) begin
            r_next.st = MSFS_LOCK_MAN;
          end
        end
      end
      MSFS_LOCK_MAN: begin
        r_next.pl_fault = 1'b0;
        if (nr_cond) begin
          r_next.st = MSFS_LOCK_NR;
        end else if (rs_cond) begin
          r_next.st = MSFS_LOCK_RS;
        end else if (!ar_cond &&
                     ((!input_rst && run_rise) ||
                      (input_rst && cmd.fault_reset))) begin
          r_next.st      = MSFS_OK;
          r_next.retries = 3'd0;
        end
      end
    endcase
    if (r_next.st != MSFS_LOCK_AR) begin
      r_next.retry_cnt = 36'd0;
    end
    if (r_next.st != MSFS_LOCK_NR) begin
      r_next.cs_lost = 1'b0;
    end

    // history shifts in on entry to a more severe class
    if (rank(r_next.st) > rank(r_reg.st)) begin
      for (int i = `MSFS_HIST_DEPTH - 1; i > 0; i--) begin
        r_next.hist[i] = r_reg.hist[i-1];
      end
      r_next.hist[0] = top;
    end

    // run command: 2-wire level, 3-wire latched start edge
    if ((r_next.st != MSFS_OK) || cmd.stop) begin
      r_next.start_latch = 1'b0;
    end else if (run_rise && (r_reg.st == MSFS_OK)) begin
      r_next.start_latch = 1'b1;
    end
    r_next.out.motor_drive = (r_next.st == MSFS_OK) &&
      (three_wire ? r_next.start_latch : cmd.run);

    // relays
    r_next.out.second_relay_output = (r_next.st == MSFS_OK);
    unique case (r_next.st)
      MSFS_OK:       r_next.out.fault_isolation_relay = 1'b1;
      MSFS_LOCK_NR:  r_next.out.fault_isolation_relay =
                       r_reg.out.motor_drive;
      MSFS_LOCK_RS:  r_next.out.fault_isolation_relay = ~iso;
      MSFS_LOCK_AR:  r_next.out.fault_isolation_relay = ~iso;
      MSFS_LOCK_MAN: r_next.out.fault_isolation_relay = 1'b0;
    endcase

    // flashing fault code
    if (r_reg.flash_cnt >= FLASH_CYC - 27'd1) begin
      r_next.flash_cnt = 27'd0;
      r_next.flash     = ~r_reg.flash;
    end else begin
      r_next.flash_cnt = r_reg.flash_cnt + 27'd1;
    end
    if (r_next.st == MSFS_OK) begin
      r_next.code = MSFS_FC_NONE;
    end else if ((r_next.st == MSFS_LOCK_NR) && !nr_cond) begin
      r_next.code = r_reg.code;
    end else begin
      r_next.code = top;
    end
    r_next.out.fault_code = r_next.code;
    r_next.out.display_on = (r_next.code != MSFS_FC_NONE) &&
                            r_next.flash;

    // apb answer one cycle after setup
    r_next.pready  = psel & ~penable;
    r_next.pslverr = 1'b0;
    r_next.prdata  = 32'h0000_0000;
    if (psel & ~penable) begin
      if (addr_hit(paddr, `MSFS_CTRL_OFS)) begin
        r_next.prdata = {16'h0000, r_reg.ctrl};
      end else if (addr_hit(paddr, `MSFS_CMD_OFS)) begin
        r_next.prdata = 32'h0000_0000;
      end else if (addr_hit(paddr, `MSFS_STATUS_OFS) && apb_rd) begin
        r_next.prdata[`MSFS_ST_STATE_LSB +: 3] = r_reg.st;
        r_next.prdata[`MSFS_ST_CODE_LSB +: 4]  = r_reg.code;
        r_next.prdata[`MSFS_ST_RETRY_LSB +: 3] = r_reg.retries;
        r_next.prdata[`MSFS_ST_RELAY1]  = r_reg.out.fault_isolation_relay;
        r_next.prdata[`MSFS_ST_RELAY2]  = r_reg.out.second_relay_output;
        r_next.prdata[`MSFS_ST_DRIVE]   = r_reg.out.motor_drive;
        r_next.prdata[`MSFS_ST_CFG_PU]  = r_reg.cfg_pu;
        r_next.prdata[`MSFS_ST_CFG_SER] = r_reg.cfg_ser;
      end else if (hist_sel && apb_rd) begin
        r_next.prdata[3:0] = r_reg.hist[hist_idx];
      end else begin
        r_next.pslverr = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg      <= '0;
      r_reg.st   <= MSFS_OK;
      r_reg.code <= MSFS_FC_NONE;
      r_reg.ctrl <= `MSFS_CTRL_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  assign prdata  = r_reg.prdata;
  assign pready  = r_reg.pready;
  assign pslverr = r_reg.pslverr;
  assign outs    = r_reg.out;

endmodule : msfs_supervisor

// File: msfs_motor_model.sv
// motor model: phase current that follows the supervisor's drive output
// assumes the bench can cut a motor phase to starve the current
`timescale 1ns/100ps
module msfs_motor_model (
  input  wire logic       pclk,
  input  wire logic       drive,
  input  wire logic       phase_cut,
  output logic      [7:0] current
);
  // current appears one cycle after drive, none with a cut phase
  always_ff @(posedge pclk) begin
    current <= (drive && !phase_cut) ? 8'hA0 : 8'h00;
  end
endmodule : msfs_motor_model

// File: msfs_supervisor_assertions.sv
// concurrent checks on the ports of the fault supervisor
// assumes the bench shortens the phase-loss count, handed on by bind
`timescale 1ns/100ps
`include "msfs_defs.svh"
module msfs_supervisor_assertions #(
  parameter logic [26:0] PL_3PH_CYC = 27'd20
) (
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [7:0]          paddr,
  input wire logic [31:0]         pwdata,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire msfs_pkg::msfs_mon_t mon,
  input wire msfs_pkg::msfs_cmd_t cmd,
  input wire msfs_pkg::msfs_out_t outs
);
  import msfs_pkg::*;
  // ----
  // low-current run length while driving
  // ----
  logic [26:0] lo_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lo_cnt <= '0;
    end else if (outs.motor_drive && mon.motor_current == 8'h00) begin
      lo_cnt <= lo_cnt + 27'd1;
    end else begin
      lo_cnt <= '0;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  chk_nr_lock: assert property (
    mon.overcurrent |=> !outs.second_relay_output && !outs.motor_drive)
    else $error("drive or second relay on after overcurrent");
  chk_nr_relay1: assert property (
    mon.overcurrent |=> ##1 !outs.fault_isolation_relay)
    else $error("isolation relay still closed after lockout");
  chk_nr_hold: assert property (
    outs.fault_code inside {MSFS_FC_OVERCURRENT, MSFS_FC_PHASE_INV} &&
    mon.ctl_supply_present && $past(mon.ctl_supply_present)
    |=> $stable(outs.fault_code))
    else $error("latched fault released without supply cycling");
  chk_rs_lock: assert property (
    mon.serial_cfg_bad |-> ##[1:2]
    (!outs.second_relay_output && !outs.motor_drive))
    else $error("no lockout after serial config fault");
  chk_ar_lock: assert property (
    mon.line_phase_lost |-> ##[1:2] !outs.motor_drive)
    else $error("motor still driven with a line phase lost");
  chk_flash_code: assert property (
    outs.display_on |-> outs.fault_code != MSFS_FC_NONE)
    else $error("display lit without a fault code");
  chk_loss_time: assert property (
    lo_cnt <= PL_3PH_CYC + 27'd3)
    else $error("phase loss not flagged in time");
  chk_apb_ready: assert property (
    psel && !penable |=> pready ##1 !pready)
    else $error("ready not a single pulse after setup");
  chk_apb_unmapped: assert property (
    psel && !penable && paddr > `MSFS_HIST_LAST_OFS
    |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
endmodule : msfs_supervisor_assertions

bind msfs_supervisor msfs_supervisor_assertions #(
  .PL_3PH_CYC(PL_3PH_CYC)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .mon(mon), .cmd(cmd), .outs(outs));

// File: test_msfs_supervisor.sv
// bench for the fault supervisor: apb tasks and fault sequences
// assumes the supervisor, its checker bind and the motor model
`timescale 1ns/100ps
`include "msfs_defs.svh"
module test_msfs_supervisor;
  import msfs_pkg::*;
  localparam logic [31:0] SM = 32'h0001F7F7;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        cut, on_s, off_s;
  logic [7:0]  paddr, cur;
  logic [31:0] pwdata, prdata;
  msfs_mon_t   mb, mon;
  msfs_cmd_t   cmd;
  msfs_out_t   outs;
  int          err_count, check_count, cyc;

  msfs_supervisor #(.RETRY_CYC(36'd200), .PL_1PH_CYC(27'd50),
    .PL_3PH_CYC(27'd20), .CS_LOSS_CYC(27'd40), .FLASH_CYC(27'd4)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mon(mon), .cmd(cmd), .outs(outs));
  msfs_motor_model model (.pclk(pclk), .drive(outs.motor_drive),
    .phase_cut(cut), .current(cur));

  always_comb begin
    mon = mb;
    mon.motor_current = cur;
  end
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      give_verdict();
    end
  end
  // ----
  // tasks
  // ----
  task automatic w(input int n);
    repeat (n) @(posedge pclk);
  endtask : w
  task automatic chk(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic ok(input logic [2:0] x);
    chk("relay1_relay2_drive", x, {outs.fault_isolation_relay,
        outs.second_relay_output, outs.motor_drive});
  endtask : ok
  task automatic cc(input msfs_code_t x);
    chk("fault_code", x, outs.fault_code);
  endtask : cc
  // reads compare masked data; writes only ready and the error response
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, m, input logic xe);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    chk("pready", 1, pready);
    if (!wr) chk("prdata", d & m, prdata & m);
    chk("pslverr", xe, pslverr);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : bus
  task automatic pulse();
    cmd.run <= 1'b1;
    w(1);
    cmd.run <= 1'b0;
    w(3);
  endtask : pulse
  task automatic sup(input int n);
    mb.ctl_supply_present <= 1'b0;
    w(n);
    mb.ctl_supply_present <= 1'b1;
    w(4);
  endtask : sup
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict
  // ----
  // sequence
  // ----
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cut = 1'b0;
    cmd = '0;
    mb = '0;
    mb.ctl_supply_present = 1'b1;
    w(20);
    presetn <= 1'b1;
    w(2);
    bus(1'b0, `MSFS_CTRL_OFS, 32'h00004064, 32'hFFFFFFFF, 1'b0);
    bus(1'b0, `MSFS_STATUS_OFS, 32'h00003000, SM, 1'b0);
    bus(1'b0, 8'h20, 32'h0, 32'hFFFFFFFF, 1'b1);
    bus(1'b1, `MSFS_STATUS_OFS, 32'h0000FFFF, 32'h0, 1'b1);
    bus(1'b0, `MSFS_STATUS_OFS, 32'h00003000, SM, 1'b0);
    $display("test registers done");
    cmd.run <= 1'b1;
    w(4);
    ok(3'b111);
    mb.line_phase_lost <= 1'b1;
    w(3);
    ok(3'b100);
    cc(MSFS_FC_PHASE_LOSS);
    on_s = 1'b0;
    off_s = 1'b0;
    repeat (12) begin
      @(posedge pclk);
      on_s |= outs.display_on;
      off_s |= !outs.display_on;
    end
    chk("flash", 2'b11, {on_s, off_s});
    mb.line_phase_lost <= 1'b0;
    w(4);
    ok(3'b111);
    bus(1'b0, `MSFS_STATUS_OFS, 32'h00007000, SM, 1'b0);
    cut <= 1'b1;
    w(15);
    ok(3'b111);
    w(12);
    ok(3'b100);
    cc(MSFS_FC_PHASE_LOSS);
    cut <= 1'b0;
    w(210);
    bus(1'b0, `MSFS_STATUS_OFS, 32'h00007000, SM, 1'b0);
    $display("test auto_reset done");
    mb.line_phase_lost <= 1'b1;
    w(1100);
    bus(1'b0, `MSFS_STATUS_OFS, 32'h00001503, 32'h00003707, 1'b0);
    w(150);
    bus(1'b0, `MSFS_STATUS_OFS, 32'h00000004, 32'h00007007, 1'b0);
    mb.line_phase_lost <= 1'b0;
    w(5);
    ok(3'b000);
    cmd.run <= 1'b0;
    w(2);
    cmd.run <= 1'b1;
    w(4);
    ok(3'b111);
    $display("test retry_limit done");
    cmd.run <= 1'b0;
    w(3);
    bus(1'b1, `MSFS_CTRL_OFS, 32'h00004065, 32'h0, 1'b0);
    mb.line_freq_out <= 1'b1;
    w(3);
    cc(MSFS_FC_NONE);
    mb.line_freq_out <= 1'b0;
    pulse();
    ok(3'b111);
    bus(1'b1, `MSFS_CTRL_OFS, 32'h00004075, 32'h0, 1'b0);
    mb.line_freq_out <= 1'b1;
    w(3);
    cc(MSFS_FC_LINE_FREQ);
    mb.line_freq_out <= 1'b0;
    w(5);
    ok(3'b110);
    pulse();
    ok(3'b111);
    cmd.stop <= 1'b1;
    w(2);
    ok(3'b110);
    cmd.stop <= 1'b0;
    $display("test three_wire done");
    bus(1'b1, `MSFS_CTRL_OFS, 32'h00004066, 32'h0, 1'b0);
    cmd.run <= 1'b1;
    w(4);
    mb.serial_cfg_bad <= 1'b1;
    w(1);
    mb.serial_cfg_bad <= 1'b0;
    w(3);
    ok(3'b000);
    cc(MSFS_FC_SERIAL_CFG);
    bus(1'b0, `MSFS_STATUS_OFS, 32'h00010002, 32'h00010007, 1'b0);
    bus(1'b1, `MSFS_CMD_OFS, 32'h00000002, 32'h0, 1'b0);
    w(4);
    ok(3'b111);
    $display("test resettable done");
    bus(1'b1, `MSFS_CTRL_OFS, 32'h00004064, 32'h0, 1'b0);
    mb.overcurrent <= 1'b1;
    mb.line_phase_lost <= 1'b1;
    w(2);
    ok(3'b100);
    cc(MSFS_FC_OVERCURRENT);
    w(1);
    ok(3'b000);
    mb.overcurrent <= 1'b0;
    mb.line_phase_lost <= 1'b0;
    cmd.run <= 1'b0;
    w(2);
    cmd.run <= 1'b1;
    w(4);
    ok(3'b000);
    sup(10);
    cc(MSFS_FC_NONE);
    mb.line_phase_order <= 1'b1;
    w(3);
    cc(MSFS_FC_PHASE_INV);
    mb.line_phase_order <= 1'b0;
    sup(10);
    cc(MSFS_FC_NONE);
    bus(1'b0, `MSFS_HIST0_OFS, 32'h3, 32'hF, 1'b0);
    bus(1'b0, `MSFS_HIST0_OFS + 8'h04, 32'h2, 32'hF, 1'b0);
    bus(1'b0, `MSFS_HIST0_OFS + 8'h08, 32'h6, 32'hF, 1'b0);
    bus(1'b1, `MSFS_CTRL_OFS, 32'h00004060, 32'h0, 1'b0);
    mb.line_phase_order <= 1'b1;
    w(3);
    cc(MSFS_FC_NONE);
    mb.line_phase_order <= 1'b0;
    $display("test non_resettable done");
    mb.ctl_supply_present <= 1'b0;
    w(30);
    cc(MSFS_FC_NONE);
    w(20);
    cc(MSFS_FC_CTL_LINE);
    mb.ctl_supply_present <= 1'b1;
    w(4);
    cc(MSFS_FC_NONE);
    bus(1'b1, `MSFS_CTRL_OFS, 32'h000040A0, 32'h0, 1'b0);
    mb.line_phase_lost <= 1'b1;
    w(3);
    ok(3'b000);
    cc(MSFS_FC_PHASE_LOSS);
    mb.line_phase_lost <= 1'b0;
    cmd.run <= 1'b0;
    w(2);
    cmd.run <= 1'b1;
    w(4);
    ok(3'b000);
    cmd.fault_reset <= 1'b1;
    w(1);
    cmd.fault_reset <= 1'b0;
    w(3);
    ok(3'b111);
    mb.cfg_invalid <= 1'b1;
    presetn <= 1'b0;
    w(3);
    presetn <= 1'b1;
    w(3);
    mb.cfg_invalid <= 1'b0;
    cc(MSFS_FC_CFG_POWERUP);
    bus(1'b1, `MSFS_CMD_OFS, 32'h00000001, 32'h0, 1'b0);
    w(3);
    cc(MSFS_FC_NONE);
    $display("test supply_and_power_up done");
    give_verdict();
  end
endmodule : test_msfs_supervisor
